/* rtl/core_pkg.sv */
// Shared constants, types and address helpers for the operand and program-address core
package core_pkg;
  localparam int              PC_W            = 21;
  localparam int              WORD_W          = 16;
  localparam int              DATA_AW         = 12;
  localparam int              RAM_DEPTH       = 4096;
  localparam logic [20:0]     PC_RESET        = 21'h000000;
  localparam logic [20:0]     PC_STEP         = 21'h000002;
  localparam logic [3:0]      BANK_RESET      = 4'h0;
  localparam logic [3:0]      BANK_TOP        = 4'hf;
  localparam logic [3:0]      BANK_ZERO       = 4'h0;
  localparam logic [7:0]      ACCESS_SPLIT    = 8'h60;
  localparam logic [4:0]      IMPL_BANKS_FULL = 5'h10;
  localparam logic [4:0]      IMPL_BANKS_HALF = 5'h08;
  localparam logic [11:0]     ADDR_PC_LOW     = 12'hff9;
  localparam logic [11:0]     ADDR_BANK_SEL   = 12'hfe0;
  localparam logic [11:0]     ADDR_WREG       = 12'hfe8;
  localparam logic [11:0]     ADDR_STATUS     = 12'hfd8;
  localparam int              STATUS_Z_BIT    = 2;
  localparam int              STATUS_N_BIT    = 4;
  localparam logic [7:0]      STATUS_RESET    = 8'h00;
  localparam logic [7:0]      STATUS_MASK     = 8'h1f;
  localparam int              PTR_INDEXED     = 2;
  localparam logic [3:0]      SECOND_TAG      = 4'hf;
  // Opcode match patterns, compared against the top bits of a word
  localparam logic [11:0]     PAT_LOAD_BANK   = 12'h010;
  localparam logic [7:0]      PAT_MOVLW       = 8'h0e;
  localparam logic [6:0]      PAT_MOVWF       = 7'h37;
  localparam logic [5:0]      PAT_MOVF        = 6'h14;
  localparam logic [6:0]      PAT_TSTFSZ      = 7'h33;
  localparam logic [4:0]      PAT_BRA         = 5'h1a;
  localparam logic [7:0]      PAT_GOTO        = 8'hef;
  localparam logic [6:0]      PAT_CALL        = 7'h76;
  localparam logic [3:0]      PAT_MOVE_FULL   = 4'hc;
  localparam logic [9:0]      PAT_LOAD_PTR    = 10'h3b8;

  typedef enum logic [3:0] {
    OP_NOP       = 4'b0000,
    OP_LOAD_BANK = 4'b0001,
    OP_MOVLW     = 4'b0010,
    OP_MOVWF     = 4'b0011,
    OP_MOVF      = 4'b0100,
    OP_TSTFSZ    = 4'b0101,
    OP_BRA       = 4'b0110,
    OP_GOTO1     = 4'b0111,
    OP_CALL1     = 4'b1000,
    OP_MOVE_FULL = 4'b1001,
    OP_LOAD_PTR  = 4'b1010,
    OP_SECOND    = 4'b1011
  } op_t;

  function automatic op_t decode_op(input logic [15:0] w);
    op_t o;
    o = OP_NOP;
    if (w[15:4] == PAT_LOAD_BANK) o = OP_LOAD_BANK;
    else if (w[15:8] == PAT_MOVLW) o = OP_MOVLW;
    else if (w[15:9] == PAT_MOVWF) o = OP_MOVWF;
    else if (w[15:10] == PAT_MOVF) o = OP_MOVF;
    else if (w[15:9] == PAT_TSTFSZ) o = OP_TSTFSZ;
    else if (w[15:11] == PAT_BRA) o = OP_BRA;
    else if (w[15:8] == PAT_GOTO) o = OP_GOTO1;
    else if (w[15:9] == PAT_CALL) o = OP_CALL1;
    else if (w[15:12] == PAT_MOVE_FULL) o = OP_MOVE_FULL;
    else if (w[15:6] == PAT_LOAD_PTR) o = OP_LOAD_PTR;
    else if (w[15:12] == SECOND_TAG) o = OP_SECOND;
    return o;
  endfunction

  function automatic logic bank_implemented(input logic [11:0] a, input logic [4:0] banks);
    return ({1'b0, a[11:8]} < banks) || (a[11:8] == BANK_TOP);
  endfunction

  function automatic logic [11:0] form_addr(input logic a_bit, input logic [7:0] ofs,
                                            input logic [3:0] bank, input logic ext,
                                            input logic [11:0] ptr);
    logic [11:0] r;
    if (a_bit) r = {bank, ofs};
    else if (ext && ofs < ACCESS_SPLIT) r = ptr + {4'h0, ofs};
    else if (ofs < ACCESS_SPLIT) r = {BANK_ZERO, ofs};
    else r = {BANK_TOP, ofs};
    return r;
  endfunction
endpackage

/* rtl/data_mem_if.sv */
// Bus between the core logic and its data RAM
`timescale 1ns/1ps
interface data_mem_if;
  logic [11:0] addr;
  logic        wr_en;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  modport ctrl (output addr, output wr_en, output wdata, input rdata);
  modport mem  (input addr, input wr_en, input wdata, output rdata);
endinterface

/* rtl/phase_gen.sv */
// Four-phase instruction cycle divider
`timescale 1ns/1ps
module phase_gen (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  output logic      [1:0] q_phase_out
);
  typedef struct packed {
    logic [1:0] q;
  } phase_state_t;
  phase_state_t st_reg;
  phase_state_t st_next;
  always_comb begin
    st_next   = st_reg;
    st_next.q = st_reg.q + 2'h1;
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_reg.q <= 2'h0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign q_phase_out = st_reg.q;
endmodule

/* rtl/data_store.sv */
// Data RAM with registered read
`timescale 1ns/1ps
module data_store (
  input  wire logic ref_clk_in,
  data_mem_if.mem   bus
);
  import core_pkg::*;
  typedef struct packed {
    logic [7:0] rdata;
  } store_state_t;
  logic [7:0]   mem [RAM_DEPTH];
  store_state_t st_reg;
  store_state_t st_next;
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = mem[bus.addr];
  end
  always_ff @(posedge ref_clk_in) begin
    st_reg <= st_next;
    if (bus.wr_en) begin
      mem[bus.addr] <= bus.wdata;
    end
  end
  assign bus.rdata = st_reg.rdata;
endmodule

/* rtl/core_operand_address_banking.sv */
// Operand addressing, bank select and program counter logic of the core
//
// Functional notes
// - Program store is byte addressed; instruction words start at even byte addresses.
// - Program counter steps by two and its bit zero always reads zero.
// - Jump and call targets are word addresses loaded into counter bits 20..1.
// - Relative branch offset counts single-word instructions, not bytes.
// - Second word of the four two-word instructions starts 1111, twelve literal bits.
// - A 1111 word supplies operand after its first word, else runs as no-op.
// - Data addresses are 12 bits: 16 banks of 256 bytes.
// - Variant implements all 16 banks or only the first eight plus bank 15.
// - Reading an unimplemented data location returns zero.
// - Banked address is bank select as top four bits plus opcode offset.
// - Bank select keeps only bits 3..0; upper bits read zero, ignore writes.
// - Load-bank-literal writes its literal straight into bank select.
// - Unimplemented bank writes dropped, reads zero, status updates anyway.
// - Full-address move uses both 12-bit addresses and ignores bank select.
// - Access map: offsets 00-5F to bank 0, 60-FF to bank 15.
// - Access-select bit 1 uses bank select, 0 uses the access map.
// - Access map lets an instruction reach data in one cycle, no bank load.
// - Banked write to F9 with bank 0F lands on counter low byte.
// - Extended set enable switches the access map to pointer-indexed low half.
// - Operand read in phase two, result written in phase four.
// - Branches and counter low-byte writes take two cycles, two-word jumps and calls three, each flushing the fetched word.
`timescale 1ns/1ps
module core_operand_address_banking #(
  parameter logic [4:0] IMPL_BANKS = core_pkg::IMPL_BANKS_FULL
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        extended_set_enable_in,
  input  wire logic [core_pkg::WORD_W-1:0] prog_data_in,
  output logic      [core_pkg::PC_W-1:0]   prog_addr_out,
  output logic      [1:0]                  q_phase_out,
  output logic      [7:0]                  bank_select_out,
  output logic      [7:0]                  w_out,
  output logic      [7:0]                  status_out,
  output logic      [core_pkg::DATA_AW-1:0] data_addr_out
);
  import core_pkg::*;

  typedef struct packed {
    logic [PC_W-1:0]    pc;
    logic [15:0]        fetch;
    logic               fetch_valid;
    logic [15:0]        ir;
    logic               ir_valid;
    logic [15:0]        hold;
    logic               second_pending;
    logic [3:0]         bank_select_reg;
    logic [7:0]         w;
    logic [7:0]         status;
    logic [7:0]         operand;
    logic [2:0][11:0]   ptr;
    logic [11:0]        data_addr;
  } core_state_t;

  core_state_t st_reg;
  core_state_t st_next;
  logic [1:0]  q;
  op_t         op;
  op_t         op_hold;
  logic        pair;
  logic        file_op;
  logic [11:0] rd_addr;
  logic [11:0] wr_addr;
  logic [7:0]  wr_data;
  logic        wr_req;
  logic        wr_ram;
  logic        redirect;
  logic        skip;
  logic [20:0] target;
  logic [7:0]  rd_value;

  data_mem_if mem_bus ();

  phase_gen u_phase (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .q_phase_out (q)
  );

  data_store u_store (
    .ref_clk_in (ref_clk_in),
    .bus        (mem_bus.mem)
  );

  always_comb begin
    st_next  = st_reg;
    op       = st_reg.ir_valid ? decode_op(st_reg.ir) : OP_NOP;
    op_hold  = decode_op(st_reg.hold);
    pair     = (op == OP_SECOND) && st_reg.second_pending;
    file_op  = (op == OP_MOVWF) || (op == OP_MOVF) || (op == OP_TSTFSZ);
    // Direct operand address: banked or access map
    rd_addr  = form_addr(st_reg.ir[8], st_reg.ir[7:0], st_reg.bank_select_reg,
                         extended_set_enable_in, st_reg.ptr[PTR_INDEXED]);
    if (pair && op_hold == OP_MOVE_FULL) begin
      rd_addr = st_reg.hold[11:0];
    end
    wr_addr  = st_reg.data_addr;
    wr_data  = 8'h00;
    wr_req   = 1'b0;
    redirect = 1'b0;
    skip     = 1'b0;
    target   = st_reg.pc + PC_STEP;
    unique case (op)
      OP_MOVWF: begin
        wr_req  = 1'b1;
        wr_data = st_reg.w;
      end
      OP_MOVF: begin
        wr_req  = st_reg.ir[9];
        wr_data = st_reg.operand;
      end
      OP_TSTFSZ: begin
        skip = (st_reg.operand == 8'h00);
      end
      OP_BRA: begin
        redirect = 1'b1;
        // Counter already points one word past the branch
        target   = st_reg.pc + {{9{st_reg.ir[10]}}, st_reg.ir[10:0], 1'b0};
      end
      OP_SECOND: begin
        if (pair && (op_hold == OP_GOTO1 || op_hold == OP_CALL1)) begin
          redirect = 1'b1;
          target   = {st_reg.ir[11:0], st_reg.hold[7:0], 1'b0};
        end else if (pair && op_hold == OP_MOVE_FULL) begin
          wr_req  = 1'b1;
          wr_addr = st_reg.ir[11:0];
          wr_data = st_reg.operand;
        end
      end
      default: begin
      end
    endcase
    // Write to the counter low byte redirects the program
    if (wr_req && wr_addr == ADDR_PC_LOW) begin
      redirect = 1'b1;
      target   = {st_reg.pc[20:8], wr_data[7:1], 1'b0};
    end
    wr_ram = wr_req && (wr_addr != ADDR_PC_LOW) && (wr_addr != ADDR_BANK_SEL)
             && (wr_addr != ADDR_WREG) && (wr_addr != ADDR_STATUS);
    // Core registers decoded here, RAM elsewhere, holes read zero
    if (st_reg.data_addr == ADDR_BANK_SEL) begin
      rd_value = {4'h0, st_reg.bank_select_reg};
    end else if (st_reg.data_addr == ADDR_WREG) begin
      rd_value = st_reg.w;
    end else if (st_reg.data_addr == ADDR_STATUS) begin
      rd_value = st_reg.status;
    end else if (st_reg.data_addr == ADDR_PC_LOW) begin
      rd_value = st_reg.pc[7:0];
    end else if (bank_implemented(st_reg.data_addr, IMPL_BANKS)) begin
      rd_value = mem_bus.rdata;
    end else begin
      rd_value = 8'h00;
    end
    unique case (q)
      2'h0: begin
        st_next.ir       = st_reg.fetch;
        st_next.ir_valid = st_reg.fetch_valid;
      end
      2'h1: begin
        st_next.data_addr = rd_addr;
      end
      2'h2: begin
        st_next.operand = rd_value;
      end
      2'h3: begin
        // Word fetched this cycle is dropped on redirect or skip
        st_next.fetch          = prog_data_in;
        st_next.fetch_valid    = !(redirect || skip);
        st_next.pc             = redirect ? target : st_reg.pc + PC_STEP;
        st_next.hold           = st_reg.ir;
        st_next.second_pending = (op == OP_GOTO1) || (op == OP_CALL1)
                                 || (op == OP_MOVE_FULL) || (op == OP_LOAD_PTR);
        if (wr_req && wr_addr == ADDR_BANK_SEL) begin
          st_next.bank_select_reg = wr_data[3:0];
        end
        if (wr_req && wr_addr == ADDR_WREG) begin
          st_next.w = wr_data;
        end
        if (wr_req && wr_addr == ADDR_STATUS) begin
          st_next.status = wr_data & STATUS_MASK;
        end
        if (op == OP_LOAD_BANK) begin
          st_next.bank_select_reg = st_reg.ir[3:0];
        end
        if (op == OP_MOVLW) begin
          st_next.w = st_reg.ir[7:0];
        end
        if (op == OP_MOVF) begin
          if (!st_reg.ir[9]) begin
            st_next.w = st_reg.operand;
          end
          // Flags follow the value even if the bank is absent
          st_next.status[STATUS_Z_BIT] = (st_reg.operand == 8'h00);
          st_next.status[STATUS_N_BIT] = st_reg.operand[7];
        end
        // Only three pointers exist; a select of 3 is dropped
        if (pair && op_hold == OP_LOAD_PTR && st_reg.hold[5:4] != 2'h3) begin
          st_next.ptr[st_reg.hold[5:4]] = {st_reg.hold[3:0], st_reg.ir[7:0]};
        end
      end
    endcase
    mem_bus.addr  = (q == 2'h3) ? wr_addr : rd_addr;
    mem_bus.wdata = wr_data;
    mem_bus.wr_en = (q == 2'h3) && wr_ram && bank_implemented(wr_addr, IMPL_BANKS);
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_reg.pc              <= PC_RESET;
      st_reg.fetch           <= 16'h0000;
      st_reg.fetch_valid     <= 1'b0;
      st_reg.ir              <= 16'h0000;
      st_reg.ir_valid        <= 1'b0;
      st_reg.hold            <= 16'h0000;
      st_reg.second_pending  <= 1'b0;
      st_reg.bank_select_reg <= BANK_RESET;
      st_reg.w               <= 8'h00;
      st_reg.status          <= STATUS_RESET;
      st_reg.operand         <= 8'h00;
      st_reg.ptr             <= '0;
      st_reg.data_addr       <= 12'h000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prog_addr_out   = st_reg.pc;
  assign q_phase_out     = q;
  assign bank_select_out = {4'h0, st_reg.bank_select_reg};
  assign w_out           = st_reg.w;
  assign status_out      = st_reg.status;
  assign data_addr_out   = st_reg.data_addr;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_end_no_redirect;
    (q == 2'h3) && !redirect;
  endsequence
  sequence s_end_redirect;
    (q == 2'h3) && redirect;
  endsequence
  sequence s_lone_second;
    (q == 2'h1) && (op == OP_SECOND) && !st_reg.second_pending;
  endsequence

  property p_pc_even;
    prog_addr_out[0] == 1'b0;
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("counter bit zero set");

  property p_pc_step;
    s_end_no_redirect |=> prog_addr_out == $past(prog_addr_out) + PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("counter did not step by two");

  property p_jump_target;
    ((q == 2'h3) && pair && op_hold == OP_GOTO1)
      |=> prog_addr_out == {$past(st_reg.ir[11:0]), $past(st_reg.hold[7:0]), 1'b0};
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

  property p_branch_words;
    ((q == 2'h3) && op == OP_BRA && !wr_req)
      |=> (prog_addr_out - $past(prog_addr_out)) == {{9{$past(st_reg.ir[10])}},
                                                      $past(st_reg.ir[10:0]), 1'b0};
  endproperty
  a_branch_words: assert property (p_branch_words) else $error("branch offset wrong");

  property p_lone_second_nop;
    s_lone_second |-> ##2 (!mem_bus.wr_en && !redirect && !skip) ##1 (w_out == $past(w_out));
  endproperty
  a_lone_second_nop: assert property (p_lone_second_nop) else $error("lone word acted");

  property p_unimpl_read_zero;
    ((q == 2'h2) && !bank_implemented(st_reg.data_addr, IMPL_BANKS))
      |=> st_reg.operand == 8'h00;
  endproperty
  a_unimpl_read_zero: assert property (p_unimpl_read_zero) else $error("hole read nonzero");

  property p_unimpl_write_drop;
    mem_bus.wr_en |-> bank_implemented(mem_bus.addr, IMPL_BANKS) && (q == 2'h3);
  endproperty
  a_unimpl_write_drop: assert property (p_unimpl_write_drop) else $error("hole written");

  property p_bank_upper_zero;
    bank_select_out[7:4] == 4'h0;
  endproperty
  a_bank_upper_zero: assert property (p_bank_upper_zero) else $error("bank upper set");

  property p_load_bank;
    ((q == 2'h3) && op == OP_LOAD_BANK)
      |=> (q == 2'h0) && bank_select_out == {4'h0, $past(st_reg.ir[3:0])};
  endproperty
  a_load_bank: assert property (p_load_bank) else $error("bank literal not loaded");

  property p_banked_addr;
    ((q == 2'h1) && file_op && st_reg.ir[8])
      |=> data_addr_out == {$past(bank_select_out[3:0]), $past(st_reg.ir[7:0])};
  endproperty
  a_banked_addr: assert property (p_banked_addr) else $error("banked address wrong");

  property p_access_high;
    ((q == 2'h1) && file_op && !st_reg.ir[8] && st_reg.ir[7:0] >= ACCESS_SPLIT)
      |=> data_addr_out == {BANK_TOP, $past(st_reg.ir[7:0])};
  endproperty
  a_access_high: assert property (p_access_high) else $error("access map wrong");

  property p_access_low;
    ((q == 2'h1) && file_op && !st_reg.ir[8] && st_reg.ir[7:0] < ACCESS_SPLIT
     && !extended_set_enable_in)
      |=> data_addr_out == {BANK_ZERO, $past(st_reg.ir[7:0])};
  endproperty
  a_access_low: assert property (p_access_low) else $error("access low wrong");

  property p_indexed_low;
    ((q == 2'h1) && file_op && !st_reg.ir[8] && st_reg.ir[7:0] < ACCESS_SPLIT
     && extended_set_enable_in)
      |=> data_addr_out == $past(st_reg.ptr[PTR_INDEXED]) + {4'h0, $past(st_reg.ir[7:0])};
  endproperty
  a_indexed_low: assert property (p_indexed_low) else $error("indexed map wrong");

  property p_full_move_src;
    ((q == 2'h1) && pair && op_hold == OP_MOVE_FULL)
      |=> data_addr_out == $past(st_reg.hold[11:0]);
  endproperty
  a_full_move_src: assert property (p_full_move_src) else $error("move src wrong");

  property p_skip_flush;
    ((q == 2'h3) && skip) |-> ##2 !st_reg.ir_valid;
  endproperty
  a_skip_flush: assert property (p_skip_flush) else $error("skipped word ran");

  property p_flush;
    s_end_redirect |-> ##2 !st_reg.ir_valid;
  endproperty
  a_flush: assert property (p_flush) else $error("fetched word not flushed");

  property p_pc_low_write;
    ((q == 2'h3) && wr_req && wr_addr == ADDR_PC_LOW)
      |=> prog_addr_out[7:0] == {$past(wr_data[7:1]), 1'b0};
  endproperty
  a_pc_low_write: assert property (p_pc_low_write) else $error("low byte not loaded");
endmodule

/* tb/prog_rom_model.sv */
// Program memory model: byte addressed, one 16-bit word per even address
`timescale 1ns/1ps
module prog_rom_model (
  input  wire logic [20:0] addr_in,
  output logic      [15:0] data_out
);
  logic [15:0] mem [0:63];

  // Bit 0 of the byte address picks nothing; the word sits at the even address
  always_comb begin
    if (addr_in[20:7] == 14'h0000) begin
      data_out = mem[addr_in[6:1]];
    end else begin
      data_out = 16'h0000;
    end
  end
endmodule

/* tb/core_operand_address_banking_tb.sv */
// Self-checking testbench running small programs through the operand and address core
`timescale 1ns/1ps
module core_operand_address_banking_tb;
  import core_pkg::*;

  logic        ref_clk;
  logic        rst;
  logic        ext;
  logic [15:0] prog_data;
  logic [20:0] pc;
  logic [1:0]  q_phase;
  logic [7:0]  bank;
  logic [7:0]  w_val;
  logic [7:0]  status;
  logic [11:0] data_addr;
  int          fail_count;
  int          check_count;

  core_operand_address_banking #(
    .IMPL_BANKS (IMPL_BANKS_HALF)
  ) dut (
    .ref_clk_in             (ref_clk),
    .rst_in                 (rst),
    .extended_set_enable_in (ext),
    .prog_data_in           (prog_data),
    .prog_addr_out          (pc),
    .q_phase_out            (q_phase),
    .bank_select_out        (bank),
    .w_out                  (w_val),
    .status_out             (status),
    .data_addr_out          (data_addr)
  );

  prog_rom_model rom (
    .addr_in  (pc),
    .data_out (prog_data)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [20:0] seen, input logic [20:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Loads a program, resets the core, lets it run and checks it parked at the halt loop
  task automatic run(input logic [15:0] p[$], input logic x, input logic [20:0] h);
    for (int i = 0; i < 64; i++) begin
      rom.mem[i] = (i < p.size()) ? p[i] : 16'h0000;
    end
    ext = x;
    rst = 1'b1;
    repeat (5) @(negedge ref_clk);
    check(pc, 21'h000000, "pc in reset");
    check(21'(bank), 21'h000000, "bank in reset");
    rst = 1'b0;
    @(negedge ref_clk);
    check(21'(q_phase), 21'h000001, "phase after release");
    repeat (119) @(negedge ref_clk);
    check(21'(q_phase), 21'h000000, "phase at run end");
    check(21'(pc >= h && pc <= h + 21'h4), 21'h1, "pc at halt loop");
  endtask

  // Counter bit 0 must never be set while running
  always @(negedge ref_clk) begin
    if (!rst) begin
      check(21'(pc[0]), 21'h0, "pc bit0");
    end
  end

  initial begin
    #20000;
    fail_count++;
    end_sim();
  end

  initial begin
    fail_count = 0;
    check_count = 0;
    // Absent bank 8: write dropped, read zero, zero flag still set; then FE0 via access map
    run('{16'h0108, 16'h0e5a, 16'h6f10, 16'h0e77, 16'h5110,
          16'h0ef3, 16'h6ee0, 16'hef07, 16'hf000}, 1'b0, 21'h00000e);
    check(21'(status[STATUS_Z_BIT]), 21'h1, "zero flag");
    check(21'(status[STATUS_N_BIT]), 21'h0, "negative flag");
    check(21'(bank), 21'h000003, "bank upper bits");
    check(21'(w_val), 21'h0000f3, "w after access store");
    check(21'(data_addr), 21'h000307, "banked address at halt");
    // Access-map store to 020, full-address move back into W with bank 3 selected
    run('{16'h0e3c, 16'h6e20, 16'h0e00, 16'h0103, 16'hc020, 16'hffe8,
          16'hef06, 16'hf000}, 1'b0, 21'h00000c);
    check(21'(w_val), 21'h00003c, "full move");
    check(21'(bank), 21'h000003, "bank literal load");
    // Skip over a two-word move, lone second word, then a word-counted branch
    run('{16'h0e00, 16'h6e30, 16'h0e42, 16'h6630, 16'hc030, 16'hffe8,
          16'hd001, 16'h0e99, 16'hef08, 16'hf000}, 1'b0, 21'h000010);
    check(21'(w_val), 21'h000042, "skip and branch");
    check(21'(w_val), 21'h000042, "branch offset in words");
    // Banked write of 0a to F9 with bank 0F redirects the counter; next word flushed
    run('{16'h010f, 16'h0e0a, 16'h6ff9, 16'h0e99, 16'h0e77, 16'hef05,
          16'hf000}, 1'b0, 21'h00000a);
    check(21'(w_val), 21'h00000a, "counter low write");
    check(21'(w_val), 21'h00000a, "redirect flush");
    check(21'(data_addr), 21'h000f05, "bank 0f address at halt");
    // Extended map: pointer 2 at 100, access offset 05 lands on 105, read back banked
    run('{16'hee21, 16'hf000, 16'h0e5a, 16'h6e05, 16'h0e00, 16'h0101,
          16'h5105, 16'hef07, 16'hf000}, 1'b1, 21'h00000e);
    check(21'(w_val), 21'h00005a, "indexed access map");
    check(21'(bank), 21'h000001, "banked read");
    end_sim();
  end
endmodule
